// file: hdl/capture_ram.sv
// Dedicated acquisition memory: one write port, one registered read port.
// Assumes one clock; nothing outside the analyzer connects to it.
`timescale 1ns/1ps

module capture_ram #(
  parameter int AW = 12,
  parameter int DW = 32
) (
  input  wire logic          core_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  // No reset: plain block memory, owned by the analyzer alone
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // capture_ram

// file: hdl/logic_analyzer_capture_buffer.sv
// Capture buffer controller of an on-chip logic analyzer, with Avalon-MM slave.
// Assumes probe and qualifier come from user logic clocked by core_clk.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "la_capture_regs.svh"

module logic_analyzer_capture_buffer
  import la_capture_pkg::*;
#(
  parameter int DEPTH        = 4096,
  parameter int SAMPLE_W     = 32,
  parameter int SEG_LOG2_MAX = 6
) (
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [SAMPLE_W-1:0] probe,
  input  wire logic                qual_in,
  output logic                     acq_active,
  output logic                     acq_done
);

  localparam int AW    = $clog2(DEPTH);
  localparam int NSEG  = 1 << SEG_LOG2_MAX;
  localparam int SW    = (SEG_LOG2_MAX > 0) ? SEG_LOG2_MAX : 1;
  localparam int CFG_W = $bits(acq_cfg_t);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (DEPTH < 2 || DEPTH > 131072 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two from 2 to 131072");
  end
  if (SAMPLE_W < 1 || SAMPLE_W > 32) begin : g_bad_width
    $error("SAMPLE_W must be 1 to 32");
  end
  if (SEG_LOG2_MAX < 0 || SEG_LOG2_MAX > 15 || SEG_LOG2_MAX >= AW) begin : g_bad_segs
    $error("SEG_LOG2_MAX must leave at least two samples per segment");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  acq_state_t             state;
  acq_cfg_t               cfg;
  acq_cfg_t               act;
  logic [SW-1:0]          seg_idx;
  logic [SW-1:0]          trig_sel;
  logic [AW-1:0]          wr_ptr;
  logic [AW:0]            post_left;
  logic [AW-1:0]          rd_addr;
  logic [SAMPLE_W-1:0]    trig_value [NSEG];
  logic [SAMPLE_W-1:0]    trig_mask  [NSEG];
  logic [AW-1:0]          trig_addr  [NSEG];
  logic [SAMPLE_W-1:0]    ram_q;
  logic [3:0]             seg_log2;
  logic [AW-1:0]          ptr_mask;
  logic [AW-1:0]          wr_addr;
  logic [AW:0]            seg_depth;
  logic [AW:0]            post_count;
  logic [SW-1:0]          last_seg;
  logic                   acquiring;
  logic                   qual_active;
  logic                   ram_we;
  logic                   trig_hit;
  logic                   finish;
  logic                   bus_req;
  logic                   bus_take;
  logic                   start_cmd;
  logic                   abort_cmd;
  logic [31:0]            next_readdata;

  // ----------------------------------------
  // Segment geometry
  // ----------------------------------------
  // Oversized counts are clamped so a segment never drops below two samples
  always_comb begin
    seg_log2 = (act.seg_log2 > 4'(SEG_LOG2_MAX)) ? 4'(SEG_LOG2_MAX) : act.seg_log2;
    seg_depth = (AW+1)'(DEPTH) >> seg_log2;
    ptr_mask  = AW'(seg_depth - (AW+1)'(1));
    last_seg  = SW'((32'd1 << seg_log2) - 32'd1);
    wr_addr   = AW'({1'b0, seg_idx} << (AW - 32'(seg_log2))) | (wr_ptr & ptr_mask);
  end

  always_comb begin
    case (act.trig_pos)
      POS_CENTER: post_count = seg_depth >> 1;
      POS_PRE:    post_count = seg_depth - (seg_depth >> `LA_EDGE_SHIFT);
      default:    post_count = seg_depth >> `LA_EDGE_SHIFT;
    endcase
    if (post_count == '0) begin
      post_count = (AW+1)'(1);
    end
  end

  // ----------------------------------------
  // Write enable and trigger
  // ----------------------------------------
  assign acquiring   = (state == ST_ARMED) || (state == ST_POST);
  assign qual_active = act.qual_en && (seg_log2 == 4'h0);
  assign ram_we      = acquiring && (!qual_active || qual_in);
  // Trigger ignores the qualifier entirely
  assign trig_hit    = (state == ST_ARMED) &&
                       (((probe ^ trig_value[seg_idx]) & trig_mask[seg_idx]) == '0);
  assign finish      = ram_we && (((state == ST_POST) && (post_left == (AW+1)'(1))) ||
                                  (trig_hit && (post_count == (AW+1)'(1))));

  // ----------------------------------------
  // Acquisition sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ST_IDLE;
      seg_idx   <= '0;
      wr_ptr    <= '0;
      post_left <= '0;
      act       <= '0;
    end else if (abort_cmd) begin
      state <= ST_IDLE;
    end else if (start_cmd) begin
      state   <= ST_ARMED;
      act     <= cfg;
      seg_idx <= '0;
      wr_ptr  <= '0;
    end else begin
      if (ram_we) begin
        wr_ptr <= (wr_ptr + AW'(1)) & ptr_mask;
      end
      case (state)
        ST_ARMED: begin
          if (trig_hit) begin
            post_left <= ram_we ? post_count - (AW+1)'(1) : post_count;
            state     <= ST_POST;
          end
        end
        ST_POST: begin
          if (ram_we) begin
            post_left <= post_left - (AW+1)'(1);
          end
        end
        default: state <= state;
      endcase
      // A one-sample post count completes on the trigger cycle itself when that sample is stored
      if (finish) begin
        if (seg_idx == last_seg) begin
          state <= ST_DONE;
        end else begin
          seg_idx <= seg_idx + SW'(1);
          wr_ptr  <= '0;
          state   <= ST_ARMED;
        end
      end
    end
  end

  // Trigger sample slot per segment, so readout can start at the oldest
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NSEG; i++) begin
        trig_addr[i] <= '0;
      end
    end else if (trig_hit && !abort_cmd && !start_cmd) begin
      trig_addr[seg_idx] <= wr_addr;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acq_active <= 1'b0;
      acq_done   <= 1'b0;
    end else begin
      acq_active <= acquiring;
      acq_done   <= (state == ST_DONE);
    end
  end

  // ----------------------------------------
  // Acquisition memory
  // ----------------------------------------
  capture_ram #(
    .AW (AW),
    .DW (SAMPLE_W)
  ) u_ram (
    .core_clk (core_clk),
    .we       (ram_we),
    .waddr    (wr_addr),
    .wdata    (probe),
    .raddr    (rd_addr),
    .rdata    (ram_q)
  );

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // Every access answers on the second cycle; that also covers the RAM read latency
  assign bus_req   = avs_read || avs_write;
  assign bus_take  = bus_req && avs_waitrequest;
  assign start_cmd = bus_take && avs_write && avs_address == `LA_OFS_CTRL &&
                     avs_byteenable[0] && avs_writedata[`LA_CTRL_START];
  assign abort_cmd = bus_take && avs_write && avs_address == `LA_OFS_CTRL &&
                     avs_byteenable[0] && avs_writedata[`LA_CTRL_ABORT];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else if (bus_take) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? next_readdata : 32'h0000_0000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (avs_address == `LA_OFS_CTRL) begin
      next_readdata[`LA_CTRL_POS_HI:`LA_CTRL_POS_LO] = cfg.trig_pos;
      next_readdata[`LA_CTRL_QUAL_EN]                = cfg.qual_en;
      next_readdata[`LA_CTRL_SEG_HI:`LA_CTRL_SEG_LO] = cfg.seg_log2;
    end else if (avs_address == `LA_OFS_STATUS) begin
      next_readdata[`LA_STAT_ACTIVE]            = acquiring;
      next_readdata[`LA_STAT_POST]              = (state == ST_POST);
      next_readdata[`LA_STAT_DONE]              = (state == ST_DONE);
      next_readdata[`LA_STAT_SEG_LO +: SW]      = seg_idx;
    end else if (avs_address == `LA_OFS_TRIG_SEL) begin
      next_readdata[SW-1:0] = trig_sel;
    end else if (avs_address == `LA_OFS_TRIG_VALUE) begin
      next_readdata[SAMPLE_W-1:0] = trig_value[trig_sel];
    end else if (avs_address == `LA_OFS_TRIG_MASK) begin
      next_readdata[SAMPLE_W-1:0] = trig_mask[trig_sel];
    end else if (avs_address == `LA_OFS_TRIG_ADDR) begin
      next_readdata[AW-1:0] = trig_addr[trig_sel];
    end else if (avs_address == `LA_OFS_RD_ADDR) begin
      next_readdata[AW-1:0] = rd_addr;
    end else if (avs_address == `LA_OFS_RD_DATA) begin
      next_readdata[SAMPLE_W-1:0] = ram_q;
    end else if (avs_address == `LA_OFS_DEPTH) begin
      next_readdata = 32'(DEPTH);
    end
  end

  // Configuration; reset leaves one circular buffer with qualifier off
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= acq_cfg_t'(CFG_W'(`LA_CTRL_RESET));
    end else if (bus_take && avs_write && avs_address == `LA_OFS_CTRL) begin
      if (avs_byteenable[0]) begin
        cfg.trig_pos <= trig_pos_t'(avs_writedata[`LA_CTRL_POS_HI:`LA_CTRL_POS_LO]);
        cfg.qual_en  <= avs_writedata[`LA_CTRL_QUAL_EN];
      end
      if (avs_byteenable[1]) begin
        cfg.seg_log2 <= avs_writedata[`LA_CTRL_SEG_HI:`LA_CTRL_SEG_LO];
      end
    end
  end

  // Read pointer steps after each data read for burst-free readout
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_sel <= '0;
      rd_addr  <= '0;
    end else if (bus_take && avs_write && avs_address == `LA_OFS_TRIG_SEL) begin
      trig_sel <= avs_writedata[SW-1:0];
    end else if (bus_take && avs_write && avs_address == `LA_OFS_RD_ADDR) begin
      rd_addr <= avs_writedata[AW-1:0];
    end else if (bus_take && avs_read && avs_address == `LA_OFS_RD_DATA) begin
      rd_addr <= rd_addr + AW'(1);
    end
  end

  // One trigger set per segment
  for (genvar g = 0; g < NSEG; g++) begin : g_trig_set
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        trig_value[g] <= '0;
        trig_mask[g]  <= `LA_TRIG_MASK_RST;
      end else if (bus_take && avs_write && trig_sel == SW'(g)) begin
        if (avs_address == `LA_OFS_TRIG_VALUE) begin
          trig_value[g] <= avs_writedata[SAMPLE_W-1:0];
        end else if (avs_address == `LA_OFS_TRIG_MASK) begin
          trig_mask[g] <= avs_writedata[SAMPLE_W-1:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic [SW-1:0] hit_seg;
  logic [AW-1:0] hit_addr;
  always_ff @(posedge core_clk) begin
    hit_seg  <= seg_idx;
    hit_addr <= wr_addr;
  end

  a_write_only_acq: assert property (ram_we |-> acquiring)
    else $error("write outside acquisition");
  a_seg_in_range: assert property (acquiring |-> seg_idx <= last_seg)
    else $error("active segment out of range");
  a_segmented_all: assert property (acquiring && seg_log2 != 4'h0 |-> ram_we)
    else $error("segmented capture skipped a cycle");
  a_qual_drops: assert property (acquiring && act.qual_en && seg_log2 == 4'h0
                                 && !qual_in |-> !ram_we)
    else $error("qualifier low still stored");
  a_cont_writes: assert property (acquiring && !act.qual_en |-> ram_we)
    else $error("continuous mode missed a write");
  a_ptr_wrap: assert property (state == ST_ARMED && ram_we && wr_ptr == ptr_mask
                               && !start_cmd && !abort_cmd |=> wr_ptr == '0)
    else $error("write pointer did not wrap");
  a_trig_to_post: assert property (trig_hit && !start_cmd && !abort_cmd
                                   |=> (state == ST_POST || $past(finish))
                                       && trig_addr[hit_seg] == hit_addr)
    else $error("trigger not recorded");
  a_seg_advance: assert property (finish && seg_idx != last_seg && !abort_cmd && !start_cmd
                                  |=> state == ST_ARMED && seg_idx == $past(seg_idx) + SW'(1)
                                      && wr_ptr == '0)
    else $error("segment did not advance");
  a_post_bound: assert property (state == ST_POST |-> post_left <= post_count)
    else $error("post count beyond trigger position");
  a_bus_answer: assert property (bus_take |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

  c_seg_trigger: cover property (trig_hit && seg_log2 != 4'h0);
  c_last_done: cover property (state == ST_POST ##1 state == ST_DONE);
  c_qual_gap: cover property (acquiring && qual_active && !qual_in ##1 ram_we);
  c_wrap_armed: cover property (state == ST_ARMED && ram_we && wr_ptr == ptr_mask);

endmodule // logic_analyzer_capture_buffer

// file: include/la_capture_pkg.sv
// Types shared by the capture buffer files.
// Assumes nothing beyond a SystemVerilog compiler.
package la_capture_pkg;

  typedef enum logic [1:0] {
    POS_POST,
    POS_CENTER,
    POS_PRE
  } trig_pos_t;

  typedef enum {
    ST_IDLE,
    ST_ARMED,
    ST_POST,
    ST_DONE
  } acq_state_t;

  typedef struct packed {
    logic [3:0] seg_log2;
    logic       qual_en;
    trig_pos_t  trig_pos;
  } acq_cfg_t;

endpackage

// file: include/la_capture_regs.svh
// Register offsets, field positions and reset values of the capture buffer.
// Assumes a 32-bit byte-addressed slave; offsets are byte addresses.
`ifndef LA_CAPTURE_REGS_SVH
`define LA_CAPTURE_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define LA_OFS_CTRL       8'h00
`define LA_OFS_STATUS     8'h04
`define LA_OFS_TRIG_SEL   8'h08
`define LA_OFS_TRIG_VALUE 8'h0C
`define LA_OFS_TRIG_MASK  8'h10
`define LA_OFS_TRIG_ADDR  8'h14
`define LA_OFS_RD_ADDR    8'h18
`define LA_OFS_RD_DATA    8'h1C
`define LA_OFS_DEPTH      8'h20

// ----------------------------------------
// CTRL fields
// ----------------------------------------
`define LA_CTRL_START     0
`define LA_CTRL_ABORT     1
`define LA_CTRL_POS_LO    2
`define LA_CTRL_POS_HI    3
`define LA_CTRL_QUAL_EN   4
`define LA_CTRL_SEG_LO    8
`define LA_CTRL_SEG_HI    11

// ----------------------------------------
// STATUS fields
// ----------------------------------------
`define LA_STAT_ACTIVE    0
`define LA_STAT_POST      1
`define LA_STAT_DONE      2
`define LA_STAT_SEG_LO    8

// ----------------------------------------
// Reset values and fixed fractions
// ----------------------------------------
`define LA_CTRL_RESET     32'h0000_0000
`define LA_TRIG_MASK_RST  32'h0000_0000
`define LA_EDGE_SHIFT     3

`endif

// file: testbench/logic_analyzer_capture_buffer_tb.sv
// Self-checking bench for the capture buffer: register checks and captures.
// Assumes probe_source drives probe and qual_in; DEPTH shrunk to 64.
`timescale 1ns/1ps
`include "la_capture_regs.svh"

module logic_analyzer_capture_buffer_tb;
  localparam int DEPTH = 64;
  logic        core_clk;
  logic        arst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] probe;
  logic        qual_in;
  logic        acq_active;
  logic        acq_done;
  int          error_cnt;
  int          n_compared;

  logic_analyzer_capture_buffer #(.DEPTH(DEPTH), .SAMPLE_W(32), .SEG_LOG2_MAX(5))
    logic_analyzer_capture_buffer_i (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .probe(probe), .qual_in(qual_in),
    .acq_active(acq_active), .acq_done(acq_done));

  probe_source #(.W(32)) probe_source_i (
    .core_clk(core_clk), .arst_n(arst_n), .probe(probe), .qual_in(qual_in));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; one idle edge follows each answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= w;
    avs_read      <= ~w;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    logic [31:0] d;
    reg_rd(`LA_OFS_CTRL, d);
    check(d, `LA_CTRL_RESET);
    reg_rd(`LA_OFS_TRIG_MASK, d);
    check(d, `LA_TRIG_MASK_RST);
    reg_rd(`LA_OFS_DEPTH, d);
    check(d, 32'(DEPTH));
    reg_rd(`LA_OFS_STATUS, d);
    check(d, 32'h0);
    reg_wr(8'h24, 32'hFFFF_FFFF);
    reg_rd(8'h24, d);
    check(d, 32'h0);
  endtask

  // One acquisition; every segment triggers on its own odd count value
  task automatic capture(input logic [1:0] pos, input logic qual, input int seg_log2);
    logic [31:0] d;
    logic [31:0] v;
    logic [31:0] ta;
    int nseg, sd, post, step, n, oldest;
    nseg = 1 << seg_log2;
    sd   = DEPTH / nseg;
    post = (pos == 2'd0) ? (sd >> `LA_EDGE_SHIFT) :
           (pos == 2'd1) ? (sd / 2) : (sd - (sd >> `LA_EDGE_SHIFT));
    // Qualifier is ignored once the memory is split
    step = (qual && nseg == 1) ? 2 : 1;
    v    = (probe + 32'd400) | 32'h1;
    for (int s = 0; s < nseg; s++) begin
      reg_wr(`LA_OFS_TRIG_SEL, 32'(s));
      reg_wr(`LA_OFS_TRIG_VALUE, v + 32'(200 * s));
      reg_wr(`LA_OFS_TRIG_MASK, 32'hFFFF_FFFF);
    end
    // Start latches the config already held, so the config goes in first
    d = (32'(pos) << `LA_CTRL_POS_LO) | (32'(qual) << `LA_CTRL_QUAL_EN)
        | (32'(seg_log2) << `LA_CTRL_SEG_LO);
    reg_wr(`LA_OFS_CTRL, d);
    reg_wr(`LA_OFS_CTRL, d | 32'h1);
    // Status flags trail the state by a cycle; let a stale done drop first
    repeat (2) @(posedge core_clk);
    check({31'h0, acq_active}, 32'h1);
    n = 0;
    while (acq_done !== 1'b1 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    check({31'h0, acq_done}, 32'h1);
    check({31'h0, acq_active}, 32'h0);
    reg_rd(`LA_OFS_STATUS, d);
    check(d & 32'h7, 32'h4);
    for (int s = 0; s < nseg; s++) begin
      reg_wr(`LA_OFS_TRIG_SEL, 32'(s));
      reg_rd(`LA_OFS_TRIG_ADDR, ta);
      check(ta / 32'(sd), 32'(s));
      oldest = (int'(ta) % sd + post) % sd;
      for (int i = 0; i < sd; i++) begin
        reg_wr(`LA_OFS_RD_ADDR, 32'(s * sd + (oldest + i) % sd));
        reg_rd(`LA_OFS_RD_DATA, d);
        check(d, v + 32'(200 * s) - 32'(step * (sd - post)) + 32'(step * i));
      end
    end
  endtask

  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic give_verdict;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Roughly ten times the expected run
  initial begin
    #600_000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    error_cnt     = 0;
    n_compared    = 0;
    arst_n        = 1'b0;
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    test_reset();
    for (int p = 0; p < 3; p++) begin
      capture(2'(p), 1'b0, 0);
    end
    capture(2'd1, 1'b1, 0);
    capture(2'd0, 1'b1, 2);
    capture(2'd2, 1'b0, 3);
    give_verdict();
  end
endmodule // logic_analyzer_capture_buffer_tb

// file: testbench/probe_source.sv
// Stand-in for the observed user logic: a free-running count on the probe.
// Assumes one clock shared with the capture buffer; the count restarts at reset.
`timescale 1ns/1ps

module probe_source #(
  parameter int W = 32
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  output logic      [W-1:0] probe,
  output logic              qual_in
);
  // ----------------------------------------
  // Sample pattern
  // ----------------------------------------
  // A count makes every stored word name its own capture cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      probe <= '0;
    end else begin
      probe <= probe + 1'b1;
    end
  end

  // Qualifier passes odd samples only, so gaps show up as steps of two
  assign qual_in = probe[0];
endmodule // probe_source
